// ### hw/atcd_pkg.sv
// Constants for the auto tuning custom setup decoder.
package atcd_pkg;
  // Register byte addresses.
  localparam logic [7:0]  ADDR_CFG      = 8'h00;
  localparam logic [7:0]  ADDR_ACTIVE   = 8'h04;
  localparam logic [7:0]  ADDR_STATUS   = 8'h08;
  // Register width and reset values.
  localparam int          CFG_W         = 16;
  localparam logic [15:0] CFG_RESET     = 16'h0000;
  // Field positions of the configuration word.
  localparam int          EST_LSB       = 0;
  localparam int          EST_MSB       = 1;
  localparam int          INR_LSB       = 2;
  localparam int          INR_MSB       = 3;
  localparam int          TRQ_LSB       = 4;
  localparam int          TRQ_MSB       = 6;
  localparam int          STIFF_BIT     = 7;
  localparam int          FIXED_BIT     = 8;
  localparam int          GSW_LSB       = 9;
  localparam int          GSW_MSB       = 10;
  // Field codes.
  localparam logic [1:0]  EST_ON        = 2'h1;
  localparam logic [1:0]  INR_UPDATE    = 2'h1;
  localparam logic [2:0]  TRQ_KEEP      = 3'h0;
  localparam logic [2:0]  TRQ_OFF       = 3'h1;
  localparam logic [2:0]  TRQ_VERTICAL  = 3'h2;
  localparam logic [2:0]  TRQ_FRIC_LOW  = 3'h3;
  localparam logic [2:0]  TRQ_FRIC_HIGH = 3'h5;
  localparam logic [1:0]  GSW_KEEP      = 2'h0;
  localparam logic [1:0]  GSW_DISABLE   = 2'h1;
  localparam logic [1:0]  GSW_ENABLE    = 2'h2;
  // Status register bit positions.
  localparam int          STAT_PEND     = 0;
  localparam int          STAT_STOPPED  = 1;
  localparam int          STAT_CONFIRM  = 2;
  // AHB transfer type bit that marks an active transfer, and the OKAY response code.
  localparam int          HTRANS_ACT    = 1;
  localparam logic [1:0]  HRESP_OKAY    = 2'h0;
endpackage : atcd_pkg

// ### hw/atcd_top.sv
// Auto tuning custom setup decoder with AHB-Lite register access.
// Function
// - Bits 1..0 enable load estimation only when they hold 1.
// - Bits 3..2 value 1 updates inertia ratio, only with estimation enabled.
// - Bits 6..4: 2 vertical axis, 3/4/5 friction low/middle/high.
// - Torque compensation choices apply only while estimation is enabled.
// - Bit 7 selects use of tuning stiffness for the basic gains.
// - Bit 8 forces normally fixed parameters to their fixed values.
// - Bits 10..9: 0 keep, 1 disable, 2 enable gain switching.
// - Stiffness, fixed and gain switching need inertia update set to 1.
// - Changes apply only after motor stops and measurement is confirmed.
`timescale 1ns/1ps
module atcd_top (
  // Clock, reset and clock enable.
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        clk_en_i,
  // AHB-Lite slave.
  input  wire logic        hsel_i,
  input  wire logic [7:0]  haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic      [1:0]  hresp_o,
  // Drive status pins.
  input  wire logic        motor_running_i,
  input  wire logic        meas_confirmed_i,
  input  wire logic        autotune_active_i,
  // Decoded settings.
  output logic             apply_o,
  output logic             load_estimation_en_o,
  output logic             inertia_ratio_update_o,
  output logic             torque_additional_value_update_o,
  output logic             torque_additional_value_clear_o,
  output logic             direction_compensation_clear_o,
  output logic             direction_compensation_load_o,
  output logic      [1:0]  friction_level_o,
  output logic             tuning_stiffness_use_o,
  output logic             fixed_param_force_o,
  output logic             gain_switch_override_o,
  output logic             gain_switch_enable_o
);

  // Pin synchronisers.
  logic run_meta_ff, run_sync_ff, conf_meta_ff, conf_sync_ff, atun_meta_ff, atun_sync_ff;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      run_meta_ff  <= 1'b1;
      run_sync_ff  <= 1'b1;
      conf_meta_ff <= 1'b0;
      conf_sync_ff <= 1'b0;
      atun_meta_ff <= 1'b0;
      atun_sync_ff <= 1'b0;
    end else if (clk_en_i) begin
      run_meta_ff  <= motor_running_i;
      run_sync_ff  <= run_meta_ff;
      conf_meta_ff <= meas_confirmed_i;
      conf_sync_ff <= conf_meta_ff;
      atun_meta_ff <= autotune_active_i;
      atun_sync_ff <= atun_meta_ff;
    end
  end

  // Bus data phase state and register file.
  logic        dp_wr_ff,  nxt_dp_wr;
  logic [7:0]  dp_addr_ff, nxt_dp_addr;
  logic [31:0] rdata_ff,  nxt_rdata;
  logic [15:0] cfg_ff,    nxt_cfg;
  logic [15:0] act_ff,    nxt_act;
  logic        pend_ff,   nxt_pend;
  logic        addr_take, cfg_write, apply_go;

  // The slave stalls while the clock enable is low, so no transfer is lost.
  assign hreadyout_o = clk_en_i;
  assign hresp_o     = atcd_pkg::HRESP_OKAY;
  assign hrdata_o    = rdata_ff;
  assign addr_take   = hsel_i & htrans_i[atcd_pkg::HTRANS_ACT] & hready_i;
  assign cfg_write   = dp_wr_ff & (dp_addr_ff == atcd_pkg::ADDR_CFG);
  assign apply_go    = pend_ff & ~run_sync_ff & conf_sync_ff;

  always_comb begin
    nxt_dp_wr   = addr_take & hwrite_i;
    nxt_dp_addr = addr_take ? haddr_i : dp_addr_ff;
    nxt_rdata   = rdata_ff;
    if (addr_take && !hwrite_i) begin
      case (haddr_i)
        atcd_pkg::ADDR_CFG:    nxt_rdata = {16'h0000, cfg_ff};
        atcd_pkg::ADDR_ACTIVE: nxt_rdata = {16'h0000, act_ff};
        atcd_pkg::ADDR_STATUS: begin
          nxt_rdata = 32'h0000_0000;
          nxt_rdata[atcd_pkg::STAT_PEND]    = pend_ff;
          nxt_rdata[atcd_pkg::STAT_STOPPED] = ~run_sync_ff;
          nxt_rdata[atcd_pkg::STAT_CONFIRM] = conf_sync_ff;
        end
        default:               nxt_rdata = 32'h0000_0000;
      endcase
    end
    nxt_cfg  = cfg_write ? hwdata_i[15:0] : cfg_ff;
    // A new write in the apply cycle stays pending: the set wins.
    nxt_pend = cfg_write ? 1'b1 : (apply_go ? 1'b0 : pend_ff);
    nxt_act  = apply_go ? cfg_ff : act_ff;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dp_wr_ff   <= 1'b0;
      dp_addr_ff <= 8'h00;
      rdata_ff   <= 32'h0000_0000;
      cfg_ff     <= atcd_pkg::CFG_RESET;
      act_ff     <= atcd_pkg::CFG_RESET;
      pend_ff    <= 1'b0;
    end else if (clk_en_i) begin
      dp_wr_ff   <= nxt_dp_wr;
      dp_addr_ff <= nxt_dp_addr;
      rdata_ff   <= nxt_rdata;
      cfg_ff     <= nxt_cfg;
      act_ff     <= nxt_act;
      pend_ff    <= nxt_pend;
    end
  end

  // Field decode of the pending word.
  logic [1:0] f_est, f_inr, f_gsw;
  logic [2:0] f_trq;
  logic       d_est, d_inr, d_trq;

  assign f_est = cfg_ff[atcd_pkg::EST_MSB:atcd_pkg::EST_LSB];
  assign f_inr = cfg_ff[atcd_pkg::INR_MSB:atcd_pkg::INR_LSB];
  assign f_trq = cfg_ff[atcd_pkg::TRQ_MSB:atcd_pkg::TRQ_LSB];
  assign f_gsw = cfg_ff[atcd_pkg::GSW_MSB:atcd_pkg::GSW_LSB];
  assign d_est = (f_est == atcd_pkg::EST_ON);
  assign d_inr = d_est & (f_inr == atcd_pkg::INR_UPDATE);
  // Torque codes above the high friction code are ignored.
  assign d_trq = d_est & (f_trq != atcd_pkg::TRQ_KEEP)
               & (f_trq <= atcd_pkg::TRQ_FRIC_HIGH);

  // Decoded output state.
  logic       apply_ff, nxt_apply;
  logic       est_ff, nxt_est, inr_ff, nxt_inr;
  logic       add_upd_ff, nxt_add_upd, add_clr_ff, nxt_add_clr;
  logic       dir_clr_ff, nxt_dir_clr, dir_load_ff, nxt_dir_load;
  logic [1:0] fric_ff, nxt_fric;
  logic       stiff_ff, nxt_stiff, fixed_ff, nxt_fixed;
  logic       gsw_ovr_ff, nxt_gsw_ovr, gsw_en_ff, nxt_gsw_en;
  logic       gsw_act_ff, nxt_gsw_act, gsw_en_act_ff, nxt_gsw_en_act;

  always_comb begin
    nxt_apply    = apply_go;
    nxt_est      = est_ff;
    nxt_inr      = inr_ff;
    nxt_add_upd  = 1'b0;
    nxt_add_clr  = 1'b0;
    nxt_dir_clr  = 1'b0;
    nxt_dir_load = 1'b0;
    nxt_fric     = fric_ff;
    nxt_stiff    = stiff_ff;
    nxt_fixed    = fixed_ff;
    nxt_gsw_ovr  = gsw_ovr_ff;
    nxt_gsw_en   = gsw_en_ff;
    if (apply_go) begin
      nxt_est = d_est;
      nxt_inr = d_inr;
      if (d_trq) begin
        if (f_trq == atcd_pkg::TRQ_OFF) begin
          nxt_add_clr = 1'b1;
          nxt_dir_clr = 1'b1;
          nxt_fric    = 2'h0;
        end else if (f_trq == atcd_pkg::TRQ_VERTICAL) begin
          nxt_add_upd = 1'b1;
          nxt_dir_clr = 1'b1;
          nxt_fric    = 2'h0;
        end else begin
          nxt_add_upd  = 1'b1;
          nxt_dir_load = 1'b1;
          nxt_fric     = 2'(f_trq - atcd_pkg::TRQ_FRIC_LOW + 3'h1);
        end
      end
      nxt_stiff = d_inr & cfg_ff[atcd_pkg::STIFF_BIT];
      nxt_fixed = d_inr & cfg_ff[atcd_pkg::FIXED_BIT];
      if (d_inr) begin
        case (f_gsw)
          atcd_pkg::GSW_DISABLE: begin
            nxt_gsw_ovr = 1'b1;
            nxt_gsw_en  = 1'b0;
          end
          atcd_pkg::GSW_ENABLE: begin
            nxt_gsw_ovr = 1'b1;
            nxt_gsw_en  = 1'b1;
          end
          default: begin
            nxt_gsw_ovr = gsw_ovr_ff;
            nxt_gsw_en  = gsw_en_ff;
          end
        endcase
      end
    end
    // Gain switching selection is only in force while auto tuning runs.
    // Built from the next values so the gain outputs move with the apply strobe.
    nxt_gsw_act    = nxt_gsw_ovr & atun_sync_ff;
    nxt_gsw_en_act = nxt_gsw_ovr & nxt_gsw_en & atun_sync_ff;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      apply_ff    <= 1'b0;
      est_ff      <= 1'b0;
      inr_ff      <= 1'b0;
      add_upd_ff  <= 1'b0;
      add_clr_ff  <= 1'b0;
      dir_clr_ff  <= 1'b0;
      dir_load_ff <= 1'b0;
      fric_ff     <= 2'h0;
      stiff_ff    <= 1'b0;
      fixed_ff    <= 1'b0;
      gsw_ovr_ff  <= 1'b0;
      gsw_en_ff   <= 1'b0;
      gsw_act_ff  <= 1'b0;
      gsw_en_act_ff <= 1'b0;
    end else if (clk_en_i) begin
      apply_ff    <= nxt_apply;
      est_ff      <= nxt_est;
      inr_ff      <= nxt_inr;
      add_upd_ff  <= nxt_add_upd;
      add_clr_ff  <= nxt_add_clr;
      dir_clr_ff  <= nxt_dir_clr;
      dir_load_ff <= nxt_dir_load;
      fric_ff     <= nxt_fric;
      stiff_ff    <= nxt_stiff;
      fixed_ff    <= nxt_fixed;
      gsw_ovr_ff  <= nxt_gsw_ovr;
      gsw_en_ff   <= nxt_gsw_en;
      gsw_act_ff  <= nxt_gsw_act;
      gsw_en_act_ff <= nxt_gsw_en_act;
    end
  end

  assign apply_o                          = apply_ff;
  assign load_estimation_en_o             = est_ff;
  assign inertia_ratio_update_o           = inr_ff;
  assign torque_additional_value_update_o = add_upd_ff;
  assign torque_additional_value_clear_o  = add_clr_ff;
  assign direction_compensation_clear_o   = dir_clr_ff;
  assign direction_compensation_load_o    = dir_load_ff;
  assign friction_level_o                 = fric_ff;
  assign tuning_stiffness_use_o           = stiff_ff;
  assign fixed_param_force_o              = fixed_ff;
  assign gain_switch_override_o           = gsw_act_ff;
  assign gain_switch_enable_o             = gsw_en_act_ff;

  // Checks.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_apply_cond;
    clk_en_i && pend_ff && !run_sync_ff && conf_sync_ff;
  endsequence

  sequence s_vertical_apply;
    s_apply_cond ##0 (f_trq == atcd_pkg::TRQ_VERTICAL) && d_est;
  endsequence

  a_apply_after_stop: assert property (
    $rose(apply_ff) |-> $past(!run_sync_ff && conf_sync_ff && pend_ff))
    else $error("Settings applied while motor ran or unconfirmed.");

  a_write_sets_pend: assert property (
    clk_en_i && cfg_write |=> pend_ff && cfg_ff == $past(hwdata_i[15:0]))
    else $error("Configuration write not held pending.");

  a_est_decode: assert property (
    apply_ff |-> est_ff == (act_ff[atcd_pkg::EST_MSB:atcd_pkg::EST_LSB] == atcd_pkg::EST_ON))
    else $error("Estimation enable does not follow bits 1 to 0.");

  a_inertia_gate: assert property (
    inr_ff |-> est_ff)
    else $error("Inertia update active without estimation.");

  a_vertical_axis: assert property (
    s_vertical_apply |=> add_upd_ff && dir_clr_ff && !dir_load_ff && fric_ff == 2'h0)
    else $error("Vertical axis mode did not update and clear.");

  a_torque_gate: assert property (
    (add_upd_ff || add_clr_ff || dir_clr_ff || dir_load_ff) |-> est_ff && apply_ff)
    else $error("Torque compensation acted without estimation.");

  a_stiff_fixed: assert property (
    apply_ff |-> stiff_ff == (inr_ff && act_ff[atcd_pkg::STIFF_BIT])
                 && fixed_ff == (inr_ff && act_ff[atcd_pkg::FIXED_BIT]))
    else $error("Stiffness or fixed selection decoded wrongly.");

  a_dep_gate: assert property (
    (stiff_ff || fixed_ff || gsw_ovr_ff && $changed(gsw_ovr_ff)) |-> inr_ff)
    else $error("Dependent selection active without inertia update.");

  a_gsw_decode: assert property (
    s_apply_cond ##0 d_inr && f_gsw == atcd_pkg::GSW_ENABLE |=> gsw_ovr_ff && gsw_en_ff)
    else $error("Gain switching enable not applied.");

  a_undef_keep: assert property (
    s_apply_cond ##0 f_gsw == 2'h3 |=> $stable(gsw_ovr_ff) && $stable(gsw_en_ff))
    else $error("Undefined gain switching code changed setup.");

endmodule : atcd_top

// ### sim/test_autotune_custom_setup_decode.sv
// Self-checking testbench for the auto tuning custom setup decoder.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("unexpected %s expected %0h seen %0h", what, exp, got); \
  end \
end
module test_autotune_custom_setup_decode;
  localparam int          TIMEOUT = 6000;
  localparam logic [15:0] DEP_W [6] = '{16'h0185, 16'h0181, 16'h0184, 16'h0186, 16'h0085,
                                         16'h0105};
  localparam logic [3:0]  DEP_E [6] = '{4'hF, 4'h8, 4'h0, 4'h0, 4'hE, 4'hD};
  localparam logic [15:0] GS_W [7]  = '{16'h0205, 16'h0605, 16'h0405, 16'h0005, 16'h0201,
                                         16'h0204, 16'h0205};
  localparam logic [1:0]  GS_E [7]  = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h2};
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        hsel_i = 1'b0;
  logic [7:0]  haddr_i = 8'h00;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic        motor_running_i = 1'b1;
  logic        meas_confirmed_i = 1'b0;
  logic        autotune_active_i = 1'b1;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic [1:0]  hresp_o;
  logic        apply_o, load_estimation_en_o, inertia_ratio_update_o;
  logic        torque_additional_value_update_o, torque_additional_value_clear_o;
  logic        direction_compensation_clear_o, direction_compensation_load_o;
  logic [1:0]  friction_level_o;
  logic        tuning_stiffness_use_o, fixed_param_force_o;
  logic        gain_switch_override_o, gain_switch_enable_o;
  logic [15:0] word;
  logic        clk_en_i = 1'b1;
  logic [3:0]  pulses;
  logic [3:0]  dep_bits;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          cycle_cnt = 0;

  atcd_top uut (
    .clk_i(clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hready_i(hreadyout_o),
    .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .motor_running_i(motor_running_i), .meas_confirmed_i(meas_confirmed_i),
    .autotune_active_i(autotune_active_i), .apply_o(apply_o),
    .load_estimation_en_o(load_estimation_en_o), .inertia_ratio_update_o(inertia_ratio_update_o),
    .torque_additional_value_update_o(torque_additional_value_update_o),
    .torque_additional_value_clear_o(torque_additional_value_clear_o),
    .direction_compensation_clear_o(direction_compensation_clear_o),
    .direction_compensation_load_o(direction_compensation_load_o),
    .friction_level_o(friction_level_o), .tuning_stiffness_use_o(tuning_stiffness_use_o),
    .fixed_param_force_o(fixed_param_force_o), .gain_switch_override_o(gain_switch_override_o),
    .gain_switch_enable_o(gain_switch_enable_o));

  always #10 clk_i = ~clk_i;

  assign pulses   = {torque_additional_value_update_o, torque_additional_value_clear_o,
                     direction_compensation_clear_o, direction_compensation_load_o};
  assign dep_bits = {load_estimation_en_o, inertia_ratio_update_o, tuning_stiffness_use_o,
                     fixed_param_force_o};

  task test_done;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  always @(posedge clk_i) begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == TIMEOUT) begin
      error_cnt++;
      test_done();
    end
  end

  // One single AHB-Lite transfer: address phase, then data phase, each held until hready.
  task automatic bus(input logic [7:0] addr, input logic wr, input logic [31:0] wdata,
                     output logic [31:0] rdata);
    @(posedge clk_i);
    hsel_i   <= 1'b1;
    haddr_i  <= addr;
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wdata;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rdata = hrdata_o;
    `CHK("hresp", atcd_pkg::HRESP_OKAY, hresp_o)
  endtask : bus

  task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] d;
    bus(addr, 1'b0, 32'h0, d);
    `CHK("read data", exp, d)
  endtask : rd

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] d;
    bus(addr, 1'b1, data, d);
  endtask : wr

  // Waits for the apply strobe and leaves time just after the edge that raised it.
  task automatic wait_apply;
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (apply_o !== 1'b1 && n < 40);
    `CHK("apply", 1'b1, apply_o)
  endtask : wait_apply

  task automatic apply_word(input logic [15:0] w);
    wr(atcd_pkg::ADDR_CFG, {16'h0000, w});
    wait_apply();
  endtask : apply_word

  function automatic logic [3:0] trq_exp(input int c);
    case (c)
      1:       return 4'h6;
      2:       return 4'hA;
      3, 4, 5: return 4'h9;
      default: return 4'h0;
    endcase
  endfunction : trq_exp

  initial begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(atcd_pkg::ADDR_CFG, 32'h0);
    word = 16'((1 << 0) + (1 << 2) + (4 << 4) + (1 << 7) + (1 << 8) + (2 << 9));
    wr(atcd_pkg::ADDR_CFG, {16'h0000, word});
    rd(atcd_pkg::ADDR_CFG, 32'h05C5);
    repeat (10) @(posedge clk_i);
    rd(atcd_pkg::ADDR_STATUS, 32'h1);
    rd(atcd_pkg::ADDR_ACTIVE, 32'h0);
    motor_running_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    rd(atcd_pkg::ADDR_STATUS, 32'h3);
    rd(atcd_pkg::ADDR_ACTIVE, 32'h0);
    meas_confirmed_i <= 1'b1;
    wait_apply();
    `CHK("est", 1'b1, load_estimation_en_o)
    `CHK("inertia", 1'b1, inertia_ratio_update_o)
    `CHK("friction", 2'h2, friction_level_o)
    `CHK("pulses", 4'h9, pulses)
    `CHK("stiff fixed", 2'h3, {tuning_stiffness_use_o, fixed_param_force_o})
    `CHK("gain sw", 2'h3, {gain_switch_override_o, gain_switch_enable_o})
    rd(atcd_pkg::ADDR_ACTIVE, 32'h05C5);
    rd(atcd_pkg::ADDR_STATUS, 32'h6);
    for (int e = 0; e < 2; e++) begin
      for (int c = 0; c < 8; c++) begin
        apply_word(16'(e) | 16'(c << 4));
        `CHK("est", e == 1, load_estimation_en_o)
        `CHK("pulses", (e == 1) ? trq_exp(c) : 4'h0, pulses)
        if (e == 1 && c >= 3 && c <= 5) `CHK("friction", 2'(c - 2), friction_level_o)
      end
    end
    for (int i = 0; i < 6; i++) begin
      apply_word(DEP_W[i]);
      `CHK("dependency", DEP_E[i], dep_bits)
    end
    for (int i = 0; i < 7; i++) begin
      apply_word(GS_W[i]);
      `CHK("gain sw", GS_E[i], {gain_switch_override_o, gain_switch_enable_o})
    end
    // A pending word must not apply while the clock enable freezes the block.
    @(posedge clk_i);
    motor_running_i <= 1'b1;
    wr(atcd_pkg::ADDR_CFG, 32'h0000_0005);
    clk_en_i        <= 1'b0;
    motor_running_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    `CHK("frozen apply", 1'b0, apply_o)
    `CHK("frozen ready", 1'b0, hreadyout_o)
    clk_en_i <= 1'b1;
    wait_apply();
    `CHK("dependency", 4'hC, dep_bits)
    @(posedge clk_i);
    autotune_active_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    `CHK("gain sw idle", 2'h0, {gain_switch_override_o, gain_switch_enable_o})
    wr(atcd_pkg::ADDR_ACTIVE, 32'h0000FFFF);
    rd(atcd_pkg::ADDR_ACTIVE, 32'h0005);
    rd(8'h0C, 32'h0);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK("reset settings", 4'h0, dep_bits)
    `CHK("reset gain sw", 4'h0, {friction_level_o, gain_switch_override_o, gain_switch_enable_o})
    reset_i <= 1'b0;
    rd(atcd_pkg::ADDR_ACTIVE, 32'h0);
    rd(atcd_pkg::ADDR_CFG, 32'h0);
    test_done();
  end
endmodule : test_autotune_custom_setup_decode
